// file: pkg/asp_pkg.sv
// Contract
// - din captured on serial clock falling edge
// - modes 00/01/10: dout launched on falling
// - mode 11: dout launched on rising edge
// - dout high impedance while chip select high
// - interface active only while chip select low
// - conversion done low marks valid result
// - dac load acts asynchronously, active low
// - load low makes output registers transparent
// - strap high: dac inputs power up FFFh
// - strap low: dac inputs power up 000h
`default_nettype none

package asp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes and encodings
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CNT_W     = 5;
    localparam int unsigned DAC_BITS  = 12;
    localparam int unsigned DAC_NUM   = 8;
    localparam int unsigned CH_W      = 3;

    localparam logic [CNT_W-1:0]    BIT_LAST     = 5'h0F;
    localparam logic [CNT_W-1:0]    BIT_CNT_RST  = 5'h00;
    localparam logic [1:0]          MODE_RISE    = 2'h3;   // only mode that launches on rising
    localparam logic [DAC_BITS-1:0] DAC_ALL_ONES = 12'hFFF;
    localparam logic [DAC_BITS-1:0] DAC_ZERO     = 12'h000;
    localparam logic [WORD_BITS-1:0] WORD_RST    = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        ASP_ST_INIT,
        ASP_ST_IDLE,
        ASP_ST_FRAME
    } asp_state_t;

    // dac input register write request from the command decoder
    typedef struct packed {
        logic                valid;
        logic [CH_W-1:0]     ch;
        logic [DAC_BITS-1:0] data;
    } asp_dac_wr_t;

    // conversion result handed in by the converter core
    typedef struct packed {
        logic                 done;
        logic [WORD_BITS-1:0] data;
    } asp_conv_t;

endpackage : asp_pkg

`default_nettype wire

// file: src/asp_dac_chan.sv
`timescale 1ns/1ps
`default_nettype none

// one dac channel: input register plus load-gated output register
module asp_dac_chan (
    input  wire logic                          clk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          init_i,
    input  wire logic [asp_pkg::DAC_BITS-1:0]  init_val_i,
    input  wire logic                          wr_i,
    input  wire logic [asp_pkg::DAC_BITS-1:0]  wr_data_i,
    input  wire logic                          dac_load_n_i,
    output logic      [asp_pkg::DAC_BITS-1:0]  dac_o
);

    typedef struct packed {
        logic [asp_pkg::DAC_BITS-1:0] in_reg;
        logic [asp_pkg::DAC_BITS-1:0] out_reg;
    } asp_chan_st_t;

    asp_chan_st_t st_q;
    asp_chan_st_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // init wins over a write in the same cycle
    always_comb begin
        st_d = st_q;
        if (init_i) begin
            st_d.in_reg  = init_val_i;
            st_d.out_reg = init_val_i;
        end else begin
            if (wr_i) begin
                st_d.in_reg = wr_data_i;
            end
            if (!dac_load_n_i) begin
                st_d.out_reg = st_q.in_reg;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q.in_reg  <= asp_pkg::DAC_ZERO;
            st_q.out_reg <= asp_pkg::DAC_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    // the bypass needs no clock, so load takes effect at once
    assign dac_o = dac_load_n_i ? st_q.out_reg : st_q.in_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_load_transparent: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !dac_load_n_i |-> dac_o == st_q.in_reg)
        else $error("dac output not transparent while load low");

    a_load_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (dac_load_n_i && $past(dac_load_n_i) && !$past(init_i)) |-> $stable(dac_o))
        else $error("dac output moved while load high");

    a_async_update: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        ($fell(dac_load_n_i) && !$past(init_i)) |-> dac_o == $past(st_d.in_reg))
        else $error("dac output did not follow load at once");

endmodule : asp_dac_chan

`default_nettype wire

// file: src/asp_edge.sv
`timescale 1ns/1ps
`default_nettype none

// edge finder for a pin that is already synchronous to clk_i
module asp_edge #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic sig_i,
    output logic      rise_o,
    output logic      fall_o
);

    typedef struct packed {
        logic prev;
    } asp_edge_st_t;

    asp_edge_st_t st_q;
    asp_edge_st_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d      = st_q;
        st_d.prev = sig_i;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q.prev <= RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    // edges show in the same cycle as the pin change
    assign rise_o = sig_i & ~st_q.prev;
    assign fall_o = ~sig_i & st_q.prev;

endmodule : asp_edge

`default_nettype wire

// file: src/asp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

// serial pin interface of the combined converter: shift logic on the host
// serial clock, conversion-done flag and the dac register bank
module asp_serial_port (
    input  wire logic                                          clk_i,
    input  wire logic                                          arst_n_i,
    // serial pins, sampled as synchronous to clk_i
    input  wire logic                                          sclk_i,
    input  wire logic                                          cs_n_i,
    input  wire logic                                          din_i,
    output logic                                               dout_o,
    output logic                                               dout_oe_n_o,
    output logic                                               eoc_n_o,
    // dac control pins
    input  wire logic                                          dac_load_n_i,
    input  wire logic                                          powerup_level_select_i,
    output logic [asp_pkg::DAC_NUM-1:0][asp_pkg::DAC_BITS-1:0] dac_outputs_o,
    // device side
    input  wire logic [1:0]                                    clk_mode_i,
    input  wire asp_pkg::asp_conv_t                            conv_i,
    input  wire asp_pkg::asp_dac_wr_t                          dac_wr_i,
    output logic [asp_pkg::WORD_BITS-1:0]                      rx_word_o,
    output logic                                               rx_valid_o
);

    // limits of this port:
    // - sclk_i is sampled on clk_i, so each half period needs at least one clk_i cycle,
    //   or an edge is lost and the word slips by a bit
    // - the clock mode is read on every edge; change it only between frames
    // - a result that lands in the cycle a frame starts keeps the flag low,
    //   but that frame still sends the older result
    // - a frame of fewer than sixteen falls never reaches rx_word_o

    typedef struct packed {
        asp_pkg::asp_state_t           state;
        logic [asp_pkg::CNT_W-1:0]     bit_cnt;
        logic [asp_pkg::WORD_BITS-1:0] rx_shift;
        logic [asp_pkg::WORD_BITS-1:0] tx_shift;
        logic [asp_pkg::WORD_BITS-1:0] result;
        logic [asp_pkg::WORD_BITS-1:0] rx_word;
        logic                          rx_valid;
        logic                          eoc_n;
    } asp_port_st_t;

    asp_port_st_t st_q;
    asp_port_st_t st_d;

    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic cs_fall;
    logic launch;
    logic init;

    ////////////////////////////////////////////////////////////////////////////
    // pin edge finders; the host clock idles high, so a low reset value
    // would show a false rise in the first cycle after reset
    asp_edge #(.RST_VAL(1'b1)) u_sclk_edge (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .sig_i    (sclk_i),
        .rise_o   (sclk_rise),
        .fall_o   (sclk_fall)
    );

    // chip select idles high, so no false fall after reset
    asp_edge #(.RST_VAL(1'b1)) u_cs_edge (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .sig_i    (cs_n_i),
        .rise_o   (cs_rise),
        .fall_o   (cs_fall)
    );

    // launch edge depends on the programmed clock mode
    assign launch = (clk_mode_i == asp_pkg::MODE_RISE) ? sclk_rise : sclk_fall;
    assign init   = (st_q.state == asp_pkg::ASP_ST_INIT);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d          = st_q;
        st_d.rx_valid = 1'b0;
        case (st_q.state)
            asp_pkg::ASP_ST_INIT: begin
                // strap is caught by the dac bank this cycle, after reset release
                st_d.state = asp_pkg::ASP_ST_IDLE;
            end
            asp_pkg::ASP_ST_IDLE: begin
                if (!cs_n_i) begin
                    st_d.state    = asp_pkg::ASP_ST_FRAME;
                    st_d.bit_cnt  = asp_pkg::BIT_CNT_RST;
                    st_d.tx_shift = st_q.result;
                    st_d.eoc_n    = 1'b1;   // reading starts, result consumed
                end
            end
            asp_pkg::ASP_ST_FRAME: begin
                if (cs_n_i) begin
                    // partial word is dropped, not delivered
                    st_d.state    = asp_pkg::ASP_ST_IDLE;
                    st_d.bit_cnt  = asp_pkg::BIT_CNT_RST;
                    st_d.rx_shift = asp_pkg::WORD_RST;
                end else begin
                    if (sclk_fall) begin
                        st_d.rx_shift = {st_q.rx_shift[asp_pkg::WORD_BITS-2:0], din_i};
                        if (st_q.bit_cnt == asp_pkg::BIT_LAST) begin
                            st_d.bit_cnt  = asp_pkg::BIT_CNT_RST;
                            st_d.rx_word  = {st_q.rx_shift[asp_pkg::WORD_BITS-2:0], din_i};
                            st_d.rx_valid = 1'b1;
                        end else begin
                            st_d.bit_cnt = st_q.bit_cnt + 5'h01;
                        end
                    end
                    if (launch) begin
                        st_d.tx_shift = {st_q.tx_shift[asp_pkg::WORD_BITS-2:0], 1'b0};
                    end
                end
            end
            default: begin
                st_d.state = asp_pkg::ASP_ST_IDLE;
            end
        endcase
        // a new result sets the flag even in the cycle a frame clears it
        if (conv_i.done) begin
            st_d.result = conv_i.data;
            st_d.eoc_n  = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q.state    <= asp_pkg::ASP_ST_INIT;
            st_q.bit_cnt  <= asp_pkg::BIT_CNT_RST;
            st_q.rx_shift <= asp_pkg::WORD_RST;
            st_q.tx_shift <= asp_pkg::WORD_RST;
            st_q.result   <= asp_pkg::WORD_RST;
            st_q.rx_word  <= asp_pkg::WORD_RST;
            st_q.rx_valid <= 1'b0;
            st_q.eoc_n    <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin and device side outputs
    assign dout_o      = st_q.tx_shift[asp_pkg::WORD_BITS-1];
    assign dout_oe_n_o = cs_n_i | (st_q.state != asp_pkg::ASP_ST_FRAME);
    assign eoc_n_o     = st_q.eoc_n;
    assign rx_word_o   = st_q.rx_word;
    assign rx_valid_o  = st_q.rx_valid;

    ////////////////////////////////////////////////////////////////////////////
    // dac bank, strap decides the power-up code
    logic [asp_pkg::DAC_BITS-1:0] init_val;
    assign init_val = powerup_level_select_i ? asp_pkg::DAC_ALL_ONES : asp_pkg::DAC_ZERO;

    for (genvar g = 0; g < asp_pkg::DAC_NUM; g++) begin : g_dac
        asp_dac_chan u_chan (
            .clk_i        (clk_i),
            .arst_n_i     (arst_n_i),
            .init_i       (init),
            .init_val_i   (init_val),
            // channel index cast to the width of the select field
            .wr_i         (dac_wr_i.valid && (dac_wr_i.ch == asp_pkg::CH_W'(g))),
            .wr_data_i    (dac_wr_i.data),
            .dac_load_n_i (dac_load_n_i),
            .dac_o        (dac_outputs_o[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_din_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && !cs_n_i && sclk_fall) |=> st_q.rx_shift[0] == $past(din_i))
        else $error("din not captured on serial clock fall");

    a_dout_fall_mode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && !cs_n_i && clk_mode_i != asp_pkg::MODE_RISE && sclk_fall)
        |=> dout_o == $past(st_q.tx_shift[asp_pkg::WORD_BITS-2]))
        else $error("dout not launched on fall in modes 00 01 10");

    a_dout_rise_mode: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && !cs_n_i && clk_mode_i == asp_pkg::MODE_RISE)
        |=> dout_o == ($past(sclk_rise) ? $past(st_q.tx_shift[asp_pkg::WORD_BITS-2])
                                         : $past(st_q.tx_shift[asp_pkg::WORD_BITS-1])))
        else $error("dout not launched on rise in mode 11");

    a_dout_hiz: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cs_n_i |-> dout_oe_n_o)
        else $error("dout driven while chip select high");

    a_cs_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (cs_n_i && $past(cs_n_i)) |-> (!rx_valid_o && st_q.bit_cnt == asp_pkg::BIT_CNT_RST))
        else $error("shift logic active while chip select high");

    a_eoc_fall: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        conv_i.done |=> (!eoc_n_o && st_q.result == $past(conv_i.data)))
        else $error("conversion done not flagged with its result");

    a_cs_abort: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && cs_rise) |=> (st_q.bit_cnt == asp_pkg::BIT_CNT_RST && !rx_valid_o))
        else $error("partial word not aborted on chip select rise");

    a_init_ones: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (init && powerup_level_select_i) |=> dac_outputs_o[0] == asp_pkg::DAC_ALL_ONES)
        else $error("dac did not power up to all ones");

    a_init_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (init && !powerup_level_select_i) |=> dac_outputs_o[0] == asp_pkg::DAC_ZERO)
        else $error("dac did not power up to zero");

    ////////////////////////////////////////////////////////////////////////////
    // receive path
    a_valid_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rx_valid_o |=> !rx_valid_o)
        else $error("word valid held longer than one cycle");

    a_word_value: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rx_valid_o |-> (rx_word_o == st_q.rx_shift && $past(sclk_fall)))
        else $error("delivered word differs from the shifted bits");

    a_word_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !rx_valid_o |-> $stable(rx_word_o))
        else $error("received word changed without a valid pulse");

    a_last_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && !cs_n_i && sclk_fall && st_q.bit_cnt == asp_pkg::BIT_LAST)
        |=> (rx_valid_o && st_q.bit_cnt == asp_pkg::BIT_CNT_RST))
        else $error("sixteenth bit did not deliver a word");

    a_cnt_range: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        st_q.bit_cnt <= asp_pkg::BIT_LAST)
        else $error("bit counter ran past the last bit");

    ////////////////////////////////////////////////////////////////////////////
    // transmit path
    a_dout_quiet: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && !cs_n_i && !launch) |=> $stable(dout_o))
        else $error("dout moved without a launch edge");

    a_frame_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_IDLE && !cs_n_i)
        |=> (st_q.state == asp_pkg::ASP_ST_FRAME && dout_o == $past(st_q.result[asp_pkg::WORD_BITS-1])))
        else $error("frame did not start with the result msb");

    ////////////////////////////////////////////////////////////////////////////
    // frame control
    a_oe_frame: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!cs_n_i && st_q.state == asp_pkg::ASP_ST_FRAME) |-> !dout_oe_n_o)
        else $error("dout not driven inside a frame");

    a_oe_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state != asp_pkg::ASP_ST_FRAME) |-> dout_oe_n_o)
        else $error("dout driven outside a frame");

    a_idle_still: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_IDLE && cs_n_i) |=> $stable(st_q.rx_shift))
        else $error("shift register moved while deselected");

    a_valid_in_frame: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        rx_valid_o |-> ($past(st_q.state) == asp_pkg::ASP_ST_FRAME && !$past(cs_n_i)))
        else $error("word delivered from outside a frame");

    a_abort_clean: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_FRAME && cs_n_i)
        |=> (st_q.state == asp_pkg::ASP_ST_IDLE && st_q.rx_shift == asp_pkg::WORD_RST))
        else $error("aborted frame left shift state behind");

    ////////////////////////////////////////////////////////////////////////////
    // conversion flag
    a_eoc_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (st_q.state == asp_pkg::ASP_ST_IDLE && !cs_n_i && !conv_i.done) |=> eoc_n_o)
        else $error("conversion flag not cleared by a read");

    a_eoc_stands: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!eoc_n_o && !(st_q.state == asp_pkg::ASP_ST_IDLE && !cs_n_i)) |=> !eoc_n_o)
        else $error("conversion flag dropped before a read");

    ////////////////////////////////////////////////////////////////////////////
    // power-up
    a_init_once: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        init |=> !init)
        else $error("power-up cycle repeated");

    // every channel, not only the first, must take the strap code
    for (genvar k = 0; k < asp_pkg::DAC_NUM; k++) begin : g_init_chk
        a_chan_powerup: assert property (@(posedge clk_i) disable iff (!arst_n_i)
            init |=> dac_outputs_o[k] == $past(init_val))
            else $error("dac channel missed its power-up code");
    end

    c_load_write: cover property (@(posedge clk_i) disable iff (!arst_n_i) !dac_load_n_i && dac_wr_i.valid);
    c_full_word: cover property (@(posedge clk_i) disable iff (!arst_n_i) rx_valid_o);
    c_abort: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        st_q.state == asp_pkg::ASP_ST_FRAME && cs_rise && st_q.bit_cnt != asp_pkg::BIT_CNT_RST);
    c_rise_mode: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        !cs_n_i && clk_mode_i == asp_pkg::MODE_RISE && sclk_rise);
    c_eoc_read: cover property (@(posedge clk_i) disable iff (!arst_n_i) !eoc_n_o ##1 cs_fall);

endmodule : asp_serial_port

`default_nettype wire

// file: verification/asp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// serial host on the far side: sclk idles high and stands still between frames
module asp_host_model (
    input  wire logic clk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_n_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      din_o
);
    wire logic line;

    ////////////////////////////////////////////////////////////////////////////
    // a released output floats, so a stale bit can never pass for data
    assign line = dout_oe_n_i ? 1'bz : dout_i;

    // idle levels from time zero
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one frame of n bits, msb first; hp is the half period in clk cycles
    // hi is sampled just before each fall, lo just before each rise, at the end of the low phase
    task automatic frame(input logic [31:0] w, input int n, input int hp,
                         output logic [15:0] hi, output logic [15:0] lo, output logic oe_bad);
        oe_bad = 1'b0;
        hi     = 16'h0000;
        lo     = 16'h0000;
        @(negedge clk_i) cs_n_o <= 1'b0;
        repeat (2) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            din_o <= w[n-1-i];
            repeat (hp) @(negedge clk_i);
            if (i < 16) hi[15-i] = line;
            oe_bad |= (dout_oe_n_i !== 1'b0);
            sclk_o <= 1'b0;
            repeat (hp) @(negedge clk_i);
            if (i < 16) lo[15-i] = line;
            sclk_o <= 1'b1;
        end
        @(negedge clk_i);
        cs_n_o <= 1'b1;
        // released data line shows the inverse of its last bit
        din_o  <= ~din_o;
    endtask : frame
endmodule : asp_host_model

`default_nettype wire

// file: verification/tb_asp_serial_port.sv
`timescale 1ns/1ps
`default_nettype none

module tb_asp_serial_port;
    logic                 clk_i, arst_n_i, sclk, cs_n, din, dout, dout_oe_n, eoc_n;
    logic                 dac_load_n, strap, rx_valid, oe_bad;
    logic [1:0]           mode;
    logic [15:0]          rx_word, seed, res, hi, lo;
    asp_pkg::asp_conv_t   conv;
    asp_pkg::asp_dac_wr_t dwr;
    logic [asp_pkg::DAC_NUM-1:0][asp_pkg::DAC_BITS-1:0] dac_out;
    int                   fails, checks, nrx;
    int                   m_in[8], m_out[8];
    logic [15:0]          expq[$];

    asp_serial_port u_asp_serial_port (.clk_i, .arst_n_i, .sclk_i(sclk), .cs_n_i(cs_n),
        .din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .eoc_n_o(eoc_n),
        .dac_load_n_i(dac_load_n), .powerup_level_select_i(strap), .dac_outputs_o(dac_out),
        .clk_mode_i(mode), .conv_i(conv), .dac_wr_i(dwr), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid));

    asp_host_model u_host (.clk_i, .dout_i(dout), .dout_oe_n_i(dout_oe_n), .sclk_o(sclk),
        .cs_n_o(cs_n), .din_o(din));

    ////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    // every received word is matched against the queue of words sent
    always @(negedge clk_i) begin
        if (rx_valid === 1'b1) begin
            nrx++;
            check(expq.size() != 0, 1);
            if (expq.size() != 0) check(rx_word, expq.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // model: outputs follow inputs while load is low, hold otherwise
    task automatic chk_dac();
        for (int c = 0; c < 8; c++) check(dac_out[c], dac_load_n ? m_out[c] : m_in[c]);
        // while load is low the output registers keep catching the inputs
        if (!dac_load_n) m_out = m_in;
    endtask : chk_dac

    task automatic do_reset(input logic s);
        @(negedge clk_i);
        arst_n_i = 1'b0;
        strap    = s;
        repeat (20) @(negedge clk_i);
        arst_n_i = 1'b1;
        for (int c = 0; c < 8; c++) m_in[c] = s ? 'hFFF : 0;
        m_out = m_in;
        repeat (2) @(negedge clk_i);
    endtask : do_reset

    // caller lowers valid after a burst, so back to back writes stay legal
    task automatic dac_wr(input int c, input logic [11:0] d);
        dwr.valid = 1'b1;
        dwr.ch    = 3'(c);
        dwr.data  = d;
        @(negedge clk_i);
        m_in[c] = d;
        if (!dac_load_n) m_out[c] = d;
    endtask : dac_wr

    task automatic conv_pulse(input logic [15:0] d);
        conv.data = d;
        conv.done = 1'b1;
        @(negedge clk_i);
        conv.done = 1'b0;
        @(negedge clk_i);
        check(eoc_n, 0);
    endtask : conv_pulse

    task automatic xfer(input logic [31:0] w, input int n, input int hp, input logic [1:0] md,
                        input logic [15:0] r);
        mode = md;
        for (int k = 0; k < n / 16; k++) expq.push_back(16'(w >> (n - 16 * (k + 1))));
        u_host.frame(w, n, hp, hi, lo, oe_bad);
        check(hi, r);
        check(lo[15:1], (md == 2'h3) ? r[15:1] : r[14:0]);
        check(oe_bad, 0);
        @(negedge clk_i);
        check(dout_oe_n, 1);
        check(eoc_n, 1);
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        arst_n_i   = 1'b0;
        strap      = 1'b1;
        dac_load_n = 1'b1;
        mode       = 2'h0;
        conv       = '0;
        dwr        = '0;
        seed       = 16'hEAFD;
        do_reset(1'b1);
        chk_dac();
        for (int c = 0; c < 8; c++) dac_wr(c, 12'(rnd()));
        dwr.valid = 1'b0;
        @(negedge clk_i);
        chk_dac();
        dac_load_n = 1'b0;
        #1;
        chk_dac();
        @(negedge clk_i);
        dac_wr(2, 12'(rnd()));
        dwr.valid = 1'b0;
        @(negedge clk_i);
        chk_dac();
        dac_load_n = 1'b1;
        dac_wr(5, 12'(rnd()));
        dwr.valid = 1'b0;
        @(negedge clk_i);
        chk_dac();
        // every clock mode, two words per frame, host speed varied
        for (int m = 0; m < 4; m++) begin
            res = rnd();
            conv_pulse(res);
            xfer({rnd(), rnd()}, 32, m + 2, 2'(m), res);
        end
        // partial word dropped, next frame starts clean
        res = rnd();
        conv_pulse(res);
        u_host.frame({16'h0000, rnd()}, 5, 2, hi, lo, oe_bad);
        xfer({16'h0000, rnd()}, 16, 3, 2'h1, res);
        for (int i = 0; i < 50 && expq.size() != 0; i++) @(negedge clk_i);
        check(expq.size(), 0);
        check(nrx, 9);
        do_reset(1'b0);
        chk_dac();
        final_report();
    end
endmodule : tb_asp_serial_port

`default_nettype wire
